// >>> design/tcam_regs.sv
// Operation
// - Per-channel two-byte linear offset, reset zero
// - Reported temperature is raw times reciprocal plus offset
// - Seven-byte mask blocks matching faults from alert
// - Mask bytes follow status byte order
// - Mask clears fully at reset
// - Tempco bit 7 picks internal or external sensor
// - Factor bits scale resistance per 100 ppm step
// - Correction opposes positive sensing coefficient
//
// Command bank for external temperature offset, alert fault mask and current-sense tempco.
// Assumes the serial host logic decodes commands and drives a one-cycle read or write
// strobe with the command code, the selected page and up to seven data bytes.
// Measurement and status inputs come from logic on the same clock and are used
// without synchronisers.
`timescale 1ns/10ps
`default_nettype none
module tcam_regs #(
    parameter int NUM_CHAN = 2
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Command port from the host logic
    input wire logic [0:0] page,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [55:0] cmd_wdata,
    output logic [55:0] cmd_rdata,
    output logic cmd_unsupported,
    // Measurement inputs, all from core-clock logic
    input wire logic [NUM_CHAN*16-1:0] ext_diode_input,
    input wire logic [NUM_CHAN*16-1:0] ext_temp_scale_recip,
    input wire logic [15:0] int_temp,
    input wire logic [NUM_CHAN*16-1:0] current_cal_gain,
    // Fault status bytes, same layout as the mask
    input wire logic [55:0] fault_status,
    output logic alert_output_n,
    // Results
    output logic [NUM_CHAN*32-1:0] ext_temp_reported,
    output logic [NUM_CHAN*16-1:0] tempco_temp,
    output logic [NUM_CHAN*48-1:0] sense_resistance
);
    // Stored command values. Paged commands keep one entry per channel, while the
    // alert mask is a single word shared by both channels, since alert is one pin.
    // The page input is one bit wide, so only channels 0 and 1 can be addressed.
    logic [15:0] ext_temp_offset [NUM_CHAN];
    logic [15:0] next_ext_temp_offset [NUM_CHAN];
    logic [55:0] alert_fault_mask;
    logic [55:0] next_alert_fault_mask;
    logic [7:0] current_sense_tempco [NUM_CHAN];
    logic [7:0] next_current_sense_tempco [NUM_CHAN];
    // Read answer
    logic [55:0] next_cmd_rdata;
    logic next_cmd_unsupported;
    logic next_alert_output_n;
    // Per-channel results
    logic [31:0] next_ext_temp_reported [NUM_CHAN];
    logic [15:0] next_tempco_temp [NUM_CHAN];
    logic [47:0] next_sense_resistance [NUM_CHAN];
    logic [31:0] offset_fix [NUM_CHAN];

    // True for a command code this bank owns; used to flag strobes for other codes.
    // Other banks answer their own codes, so the flag only says that this bank
    // stayed silent; it is not an error by itself.
    function automatic logic cmd_is_ours(input logic [7:0] code);
        return (code == tcam_pkg::CMD_EXT_TEMP_OFFSET) ||
               (code == tcam_pkg::CMD_ALERT_FAULT_MASK) ||
               (code == tcam_pkg::CMD_CURRENT_SENSE_TEMPCO);
    endfunction

    // Register writes; paged commands go to the channel named by page.
    // A strobe that arrives while clk_en is low is lost: the flops below do not load,
    // so the host logic must keep its strobe for a cycle in which the bank is enabled.
    // Writes to codes outside this bank change nothing here.
    always_comb begin
        next_alert_fault_mask = alert_fault_mask;
        for (int c = 0; c < NUM_CHAN; c++) begin
            next_ext_temp_offset[c] = ext_temp_offset[c];
            next_current_sense_tempco[c] = current_sense_tempco[c];
        end
        if (cmd_wr) begin
            if (cmd_code == tcam_pkg::CMD_EXT_TEMP_OFFSET) begin
                // Out-of-range values are stored as written; keeping range is the host's job
                next_ext_temp_offset[page] = cmd_wdata[15:0];
            end else if (cmd_code == tcam_pkg::CMD_ALERT_FAULT_MASK) begin
                // Global: one mask serves both channels
                next_alert_fault_mask = cmd_wdata;
            end else if (cmd_code == tcam_pkg::CMD_CURRENT_SENSE_TEMPCO) begin
                next_current_sense_tempco[page] = cmd_wdata[7:0];
            end
        end
    end

    // Read answer, registered; unowned codes read zero and raise the flag.
    // The data word holds between reads, so the serial logic may shift it out over
    // many cycles without copying it first. A read and a write to the same code in
    // one cycle return the old value, because the write lands at the same edge.
    always_comb begin
        next_cmd_rdata = cmd_rdata;
        next_cmd_unsupported = 1'b0;
        if (cmd_rd || cmd_wr) begin
            next_cmd_unsupported = !cmd_is_ours(cmd_code);
        end
        if (cmd_rd) begin
            if (cmd_code == tcam_pkg::CMD_EXT_TEMP_OFFSET) begin
                next_cmd_rdata = {40'h0000000000, ext_temp_offset[page]};
            end else if (cmd_code == tcam_pkg::CMD_ALERT_FAULT_MASK) begin
                next_cmd_rdata = alert_fault_mask;
            end else if (cmd_code == tcam_pkg::CMD_CURRENT_SENSE_TEMPCO) begin
                next_cmd_rdata = {48'h000000000000, current_sense_tempco[page]};
            end else begin
                next_cmd_rdata = 56'h00000000000000;
            end
        end
    end

    // Alert: any unmasked status bit pulls the pin low. Bit i of the mask gates bit i
    // of the status word, so byte k lines up with status byte k (byte 5 is unused).
    // The pin is registered so that a glitch on the status word cannot reach it;
    // the cost is one cycle of latency from fault to pin. Masking a bit only hides
    // it from the pin; the status word itself is left alone.
    always_comb begin
        next_alert_output_n = !(|(fault_status & ~alert_fault_mask));
    end

    // Offset words to fixed point, one converter per channel.
    // The converters are combinational and see the stored words, so a new offset
    // shows in the reported temperature one cycle after it is written.
    generate
        for (genvar g = 0; g < NUM_CHAN; g++) begin : g_conv
            tcam_lin11_fix #(
                .FRAC_BITS(tcam_pkg::TEMP_FRAC_BITS)
            ) u_offset_fix (
                .lin_word(ext_temp_offset[g]),
                .fix_value(offset_fix[g])
            );
        end
    endgenerate

    // Temperature and tempco arithmetic per channel.
    // Temperature results are in 1/16 degree steps. Products are kept wide enough that no
    // input combination overflows before the final slice; the reported value is
    // truncated toward minus infinity by the arithmetic shift. The loop variables
    // below are scratch values, cleared at the top so no latch is inferred.
    // The external source for tempco is the reported value, offset included.
    always_comb begin
        logic signed [32:0] scaled;
        logic signed [15:0] tsel;
        logic signed [16:0] dtemp;
        logic signed [24:0] tc_prod;
        logic signed [31:0] tc_num;
        logic signed [48:0] sense_resistance_full;
        scaled = '0;
        tsel = '0;
        dtemp = '0;
        tc_prod = '0;
        tc_num = '0;
        sense_resistance_full = '0;
        for (int c = 0; c < NUM_CHAN; c++) begin
            // Raw reading times the reciprocal of scale, back to 1/16 degree, plus offset
            scaled = 33'($signed(ext_diode_input[c*16 +: 16]) *
                         $signed({1'b0, ext_temp_scale_recip[c*16 +: 16]}));
            next_ext_temp_reported[c] = 32'(scaled >>> tcam_pkg::RECIP_FRAC_BITS)
                                        + offset_fix[c];
            // Source for tempco: internal sensor or the external reported value
            if (current_sense_tempco[c][tcam_pkg::TEMPCO_SRC_BIT]) begin
                // Host must have enabled the external input first
                tsel = next_ext_temp_reported[c][15:0];
            end else begin
                tsel = int_temp;
            end
            next_tempco_temp[c] = tsel;
            // Resistance = gain * (1 + tc * (T - 25)), tc in 100 ppm steps, scaled by
            // TEMPCO_DENOM; it grows with temperature so dividing current by it cancels
            // the element's positive coefficient rather than doubling it.
            dtemp = 17'(tsel) - 17'(tcam_pkg::TEMP_REF_DEGC << tcam_pkg::TEMP_FRAC_BITS);
            tc_prod = 25'($signed({1'b0,
                current_sense_tempco[c][tcam_pkg::TEMPCO_FACTOR_MSB:0]}) * dtemp);
            tc_num = 32'(tcam_pkg::TEMPCO_DENOM) + 32'(tc_prod);
            sense_resistance_full = 49'($signed({1'b0, current_cal_gain[c*16 +: 16]}) * tc_num);
            next_sense_resistance[c] = sense_resistance_full[47:0];
        end
    end

    // State registers; clock enable low freezes everything.
    // The reset branch loads only constants, so the flops come out of reset in a
    // known state whatever the inputs do. Results restart at zero and take their
    // first real value one enabled cycle after reset is released; the alert pin
    // stays released until then.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            alert_fault_mask <= tcam_pkg::ALERT_FAULT_MASK_RST;
            cmd_rdata <= 56'h00000000000000;
            cmd_unsupported <= 1'b0;
            alert_output_n <= 1'b1;
            for (int c = 0; c < NUM_CHAN; c++) begin
                ext_temp_offset[c] <= tcam_pkg::EXT_TEMP_OFFSET_RST;
                current_sense_tempco[c] <= tcam_pkg::CURRENT_SENSE_TEMPCO_RST;
                ext_temp_reported[c*32 +: 32] <= 32'h00000000;
                tempco_temp[c*16 +: 16] <= 16'h0000;
                sense_resistance[c*48 +: 48] <= 48'h000000000000;
            end
        end else if (clk_en) begin
            alert_fault_mask <= next_alert_fault_mask;
            cmd_rdata <= next_cmd_rdata;
            cmd_unsupported <= next_cmd_unsupported;
            alert_output_n <= next_alert_output_n;
            for (int c = 0; c < NUM_CHAN; c++) begin
                ext_temp_offset[c] <= next_ext_temp_offset[c];
                current_sense_tempco[c] <= next_current_sense_tempco[c];
                ext_temp_reported[c*32 +: 32] <= next_ext_temp_reported[c];
                tempco_temp[c*16 +: 16] <= next_tempco_temp[c];
                sense_resistance[c*48 +: 48] <= next_sense_resistance[c];
            end
        end
    end
endmodule
`default_nettype wire

// >>> design/tcam_pkg.sv
// Package for the temperature calibration, alert mask and tempco command bank.
// Assumes a byte-coded command port from the serial host logic and one core clock.
package tcam_pkg;
    // Command codes of the three commands in this bank
    localparam logic [7:0] CMD_EXT_TEMP_OFFSET = 8'hda;
    localparam logic [7:0] CMD_ALERT_FAULT_MASK = 8'hdb;
    localparam logic [7:0] CMD_CURRENT_SENSE_TEMPCO = 8'hdc;
    // Reset values
    localparam logic [15:0] EXT_TEMP_OFFSET_RST = 16'h0000;
    localparam logic [55:0] ALERT_FAULT_MASK_RST = 56'h00000000000000;
    localparam logic [7:0] CURRENT_SENSE_TEMPCO_RST = 8'h00;
    // Linear word field layout
    localparam int LIN_EXP_MSB = 15;
    localparam int LIN_EXP_LSB = 11;
    localparam int LIN_MANT_MSB = 10;
    // Mask byte positions, one per status byte
    localparam int MASK_BYTE_VOUT = 0;
    localparam int MASK_BYTE_IOUT = 1;
    localparam int MASK_BYTE_INPUT = 2;
    localparam int MASK_BYTE_TEMP = 3;
    localparam int MASK_BYTE_CML = 4;
    localparam int MASK_BYTE_UNUSED = 5;
    localparam int MASK_BYTE_MFR = 6;
    // Tempco field layout
    localparam int TEMPCO_SRC_BIT = 7;
    localparam int TEMPCO_FACTOR_MSB = 6;
    // Fixed-point temperature: 1/16 degree steps
    localparam int TEMP_FRAC_BITS = 4;
    localparam int TEMP_REF_DEGC = 25;
    // Reciprocal scale input is unsigned Q4.12
    localparam int RECIP_FRAC_BITS = 12;
    // One tempco step is 100 ppm, so 10000 steps per unit, times 16 for temperature
    localparam int TEMPCO_STEPS_PER_UNIT = 10000;
    localparam int TEMPCO_DENOM = TEMPCO_STEPS_PER_UNIT * (1 << TEMP_FRAC_BITS);
endpackage

// >>> design/tcam_lin11_fix.sv
// Converts one linear word (signed exponent, signed mantissa) to signed fixed point.
// Assumes a purely combinational use inside the core clock domain.
`timescale 1ns/10ps
`default_nettype none
module tcam_lin11_fix #(
    parameter int FRAC_BITS = 4
) (
    input wire logic [15:0] lin_word,
    output logic signed [31:0] fix_value
);
    // Fields of the word, both two's complement
    logic signed [4:0] lin_exp;
    logic signed [10:0] lin_mant;
    logic signed [6:0] shift_amt;
    logic signed [31:0] mant_wide;

    // Split the word and place the value as mantissa times two to the exponent
    always_comb begin
        lin_exp = lin_word[tcam_pkg::LIN_EXP_MSB:tcam_pkg::LIN_EXP_LSB];
        lin_mant = lin_word[tcam_pkg::LIN_MANT_MSB:0];
        mant_wide = 32'(lin_mant);
        shift_amt = 7'(lin_exp) + 7'(FRAC_BITS);
        // Negative shift drops fraction bits below the fixed-point resolution
        if (shift_amt >= 0) begin
            fix_value = mant_wide <<< shift_amt;
        end else begin
            fix_value = mant_wide >>> (-shift_amt);
        end
    end
endmodule
`default_nettype wire

// >>> test/tcam_regs_assertions.sv
// Checker for the command bank, watching only the bank's ports.
// Assumes one core clock and an async active-low reset.
`timescale 1ns/10ps
`default_nettype none
module tcam_regs_chk #(parameter int NUM_CHAN = 2) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [0:0] page,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [55:0] cmd_wdata,
    input wire logic [55:0] cmd_rdata,
    input wire logic cmd_unsupported,
    input wire logic [15:0] int_temp,
    input wire logic [55:0] fault_status,
    input wire logic alert_output_n,
    input wire logic [NUM_CHAN*16-1:0] tempco_temp
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic [55:0] mask; // Shadow of the global mask
    logic [7:0] tc0; // Shadow of the channel 0 tempco byte
    logic bad; // Strobe carrying a code outside this bank
    assign bad = (cmd_wr | cmd_rd) & !(cmd_code inside {8'hda, 8'hdb, 8'hdc});
    // Shadows update only where the bank would take a write
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mask <= 56'h0;
            tc0 <= 8'h00;
        end else if (clk_en && cmd_wr && cmd_code == 8'hdb) begin
            mask <= cmd_wdata;
        end else if (clk_en && cmd_wr && cmd_code == 8'hdc && !page) begin
            tc0 <= cmd_wdata[7:0];
        end
    end
    a_alert_mask_gate: assert property (clk_en |=> alert_output_n ==
        !(|($past(fault_status) & ~$past(mask)))) else $error("alert disagrees with mask");
    a_mask_read_back: assert property (clk_en && cmd_rd && cmd_code == 8'hdb
        |=> cmd_rdata == $past(mask)) else $error("mask readback wrong");
    a_tempco_read_back: assert property (clk_en && cmd_rd && cmd_code == 8'hdc && !page
        |=> cmd_rdata == {48'h0, $past(tc0)}) else $error("tempco readback wrong");
    a_bad_code_pulse: assert property (clk_en |=> cmd_unsupported == $past(bad))
        else $error("unsupported pulse wrong");
    a_bad_read_zero: assert property (clk_en && cmd_rd && bad |=> cmd_rdata == 56'h0)
        else $error("unknown code read not zero");
    a_rdata_holds: assert property (!(clk_en && cmd_rd) |=> $stable(cmd_rdata))
        else $error("read data moved without a read");
    a_reset_state: assert property ($rose(resetn) |->
        cmd_rdata == 56'h0 && alert_output_n) else $error("outputs not at reset values");
    a_int_source: assert property (clk_en && !tc0[7] |=>
        tempco_temp[15:0] == $past(int_temp)) else $error("internal sensor not selected");
    cover property (clk_en && alert_output_n && fault_status != 56'h0);
    cover property (cmd_unsupported);
    cover property (tc0 == 8'h27);
endmodule
bind tcam_regs tcam_regs_chk #(.NUM_CHAN(NUM_CHAN)) chk (
    .core_clk(core_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .page(page),
    .cmd_code(cmd_code),
    .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd),
    .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata),
    .cmd_unsupported(cmd_unsupported),
    .int_temp(int_temp),
    .fault_status(fault_status),
    .alert_output_n(alert_output_n),
    .tempco_temp(tempco_temp)
);
`default_nettype wire

// >>> test/tcam_host_model.sv
// Host model driving the bank's command port.
// Assumes the bank takes strobes on the rising core clock.
`timescale 1ns/10ps
`default_nettype none
module tcam_host_model (
    input wire logic core_clk,
    output var logic [0:0] page = 1'b0,
    output var logic [7:0] cmd_code = 8'h00,
    output var logic cmd_wr = 1'b0,
    output var logic cmd_rd = 1'b0,
    output var logic [55:0] cmd_wdata = 56'h0,
    input wire logic [55:0] cmd_rdata
);
    // One request; strobe stands only for the taking edge
    task automatic req(input logic w, input logic [7:0] c, input logic [0:0] p,
                       input logic [55:0] d);
        @(posedge core_clk);
        cmd_wr <= w;
        cmd_rd <= !w;
        cmd_code <= c;
        page <= p;
        cmd_wdata <= d;
        @(posedge core_clk);
        cmd_wr <= 1'b0;
        cmd_rd <= 1'b0;
        cmd_wdata <= ~d; // Released data never shows the old value
    endtask
    // Read data is taken one edge later, when it is settled
    task automatic rd(input logic [7:0] c, input logic [0:0] p, output logic [55:0] d);
        req(1'b0, c, p, 56'h0);
        @(posedge core_clk);
        d = cmd_rdata;
    endtask
endmodule
`default_nettype wire

// >>> test/tcam_regs_tb_top.sv
// Self-checking bench for the command bank.
// Assumes the bank, its checker and the host model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tcam_regs_tb_top;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic [0:0] page;
    logic [7:0] cmd_code;
    logic cmd_wr, cmd_rd, cmd_unsupported, alert_output_n;
    logic [55:0] cmd_wdata, cmd_rdata, rv;
    logic [31:0] ext_diode_input = 32'h0190_0190; // 25 degC on both channels
    logic [31:0] ext_temp_scale_recip = 32'h2000_1000; // 2.0 on ch1, 1.0 on ch0
    logic [15:0] int_temp = 16'h0320; // 50 degC
    logic [31:0] current_cal_gain = 32'h0010_0010;
    logic [55:0] fault_status = 56'h0;
    logic [63:0] ext_temp_reported;
    logic [31:0] tempco_temp;
    logic [95:0] sense_resistance;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    always #12.5 core_clk = ~core_clk;
    tcam_regs uut (
        .core_clk(core_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .page(page),
        .cmd_code(cmd_code),
        .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd),
        .cmd_wdata(cmd_wdata),
        .cmd_rdata(cmd_rdata),
        .cmd_unsupported(cmd_unsupported),
        .ext_diode_input(ext_diode_input),
        .ext_temp_scale_recip(ext_temp_scale_recip),
        .int_temp(int_temp),
        .current_cal_gain(current_cal_gain),
        .fault_status(fault_status),
        .alert_output_n(alert_output_n),
        .ext_temp_reported(ext_temp_reported),
        .tempco_temp(tempco_temp),
        .sense_resistance(sense_resistance)
    );
    tcam_host_model host (
        .core_clk(core_clk),
        .page(page),
        .cmd_code(cmd_code),
        .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd),
        .cmd_wdata(cmd_wdata),
        .cmd_rdata(cmd_rdata)
    );
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // A hang counts as a mismatch
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            host.rd(8'hda + 8'(c), 1'(c), rv);
            chk(rv, 0);
            chk(cmd_unsupported, 1'b0);
        end
        // Unknown code: flag pulses for the write and for the read
        host.req(1'b1, 8'hd9, 1'b0, 56'h5a);
        @(posedge core_clk);
        chk(cmd_unsupported, 1'b1);
        host.rd(8'hd9, 1'b0, rv);
        chk(rv, 0);
        chk(cmd_unsupported, 1'b1);
        host.req(1'b1, 8'hda, 1'b0, 56'h0005);
        host.req(1'b1, 8'hda, 1'b1, 56'hfffa);
        host.rd(8'hda, 1'b1, rv);
        chk(rv, 56'hfffa);
        chk(ext_temp_reported, {32'd752, 32'd480});
        host.req(1'b1, 8'hdc, 1'b0, 56'h27);
        host.req(1'b1, 8'hdc, 1'b1, 56'h80);
        host.rd(8'hdc, 1'b0, rv);
        chk(rv, 56'h27);
        chk(tempco_temp, {16'd752, 16'h0320});
        // Gain 16 at 160000 per unit; channel 0 adds 39 steps over 25 degrees: 1.0975
        chk(sense_resistance, {48'd2560000, 48'd2809600});
        // Clock enable low: a write is not taken
        clk_en <= 1'b0;
        host.req(1'b1, 8'hdb, 1'b0, 56'h3c);
        clk_en <= 1'b1;
        host.rd(8'hdb, 1'b0, rv);
        chk(rv, 0);
        // Each status byte is gated only by its own mask byte
        for (int k = 0; k < 7; k++) begin
            fault_status <= 56'h1 << (9 * k);
            host.req(1'b1, 8'hdb, 1'b0, 56'hff << (8 * k));
            host.rd(8'hdb, 1'b0, rv);
            chk(rv, 56'hff << (8 * k));
            chk(alert_output_n, 1'b1);
            host.req(1'b1, 8'hdb, 1'b0, ~(56'hff << (8 * k)));
            repeat (2) @(posedge core_clk);
            chk(alert_output_n, 1'b0);
        end
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        host.rd(8'hdb, 1'b0, rv);
        chk(rv, 0);
        chk(alert_output_n, 1'b0);
        complete_run();
    end
endmodule
`default_nettype wire
